// >>> logic/adcrc_pkg.sv
// constants, field layouts and carrier types of the adc result and trim register bank
`default_nettype none
package adcrc_pkg;

  localparam int ADDR_W = 12;
  localparam int IRQ_W = 10;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_IEN = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_IF = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_IFC = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_SINGLE = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_SCAN = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_SINGLE_PEEK = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_SCAN_PEEK = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_CAL = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_BIAS = 12'h03C;

  // interrupt flag positions
  localparam int IRQ_SINGLE = 0;
  localparam int IRQ_SCAN = 1;
  localparam int IRQ_SINGLE_OF = 8;
  localparam int IRQ_SCAN_OF = 9;
  localparam logic [IRQ_W-1:0] IRQ_IMPL = 10'h303;

  // converter status bit positions
  localparam int STAT_SINGLE_DV = 0;
  localparam int STAT_SCAN_DV = 1;

  // reset values and writable masks
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic [31:0] CAL_RESET = 32'h3F003F00;
  localparam logic [31:0] CAL_WMASK = 32'h7F7F7F7F;
  localparam logic [31:0] BIAS_RESET = 32'h00000747;
  localparam logic [31:0] BIAS_WMASK = 32'h00000F4F;

  // trim register layout; offsets are signed
  typedef struct packed {
    logic rsv31;
    logic [6:0] scan_gain_trim;
    logic rsv23;
    logic signed [6:0] scan_offset_trim;
    logic rsv15;
    logic [6:0] single_gain_trim;
    logic rsv7;
    logic signed [6:0] single_offset_trim;
  } adcrc_cal_t;

  // bias register layout
  typedef struct packed {
    logic [19:0] rsv_hi;
    logic [3:0] comparator_bias_level;
    logic rsv7;
    logic bias_halving;
    logic [1:0] rsv_mid;
    logic [3:0] bias_current_level;
  } adcrc_bias_t;

  // result delivery from the converter core
  typedef struct packed {
    logic strobe;
    logic [31:0] data;
  } adcrc_result_t;

endpackage
`default_nettype wire

// >>> logic/adcrc_result_slot.sv
// one result channel: data, valid flag, dma request and overflow event
`timescale 1ns/1ps
`default_nettype none
module adcrc_result_slot (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire adcrc_pkg::adcrc_result_t res, // new result from core
  input wire logic consume, // ordinary read of result
  output logic [31:0] data, // latest result
  output logic valid, // data-valid flag
  output logic dma_req, // pending dma request
  output logic overflow // one-cycle pulse, result overwritten unread
);

  typedef struct packed {
    logic [31:0] data;
    logic valid;
    logic dma;
    logic ovf;
  } adcrc_slot_t;

  adcrc_slot_t st;
  adcrc_slot_t next_st;

  // capture results; set wins over clearing read
  always_comb
  begin
    next_st = st;
    next_st.ovf = res.strobe & st.valid & ~consume;
    if (consume)
    begin
      next_st.valid = 1'b0;
      next_st.dma = 1'b0;
    end
    if (res.strobe)
    begin
      next_st.data = res.data;
      next_st.valid = 1'b1;
      next_st.dma = 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{data: adcrc_pkg::RESULT_RESET, valid: 1'b0, dma: 1'b0, ovf: 1'b0};
    else
      st <= next_st;
  end

  assign data = st.data;
  assign valid = st.valid;
  assign dma_req = st.dma;
  assign overflow = st.ovf;

endmodule
`default_nettype wire

// >>> logic/adcrc_irq.sv
// sticky interrupt flags with write-one clear, enable mask and level output
`timescale 1ns/1ps
`default_nettype none
module adcrc_irq #(
  parameter int W = 10
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] events, // one-cycle event pulses
  input wire logic [W-1:0] clr, // flags to clear this cycle
  input wire logic en_wr, // write enable register
  input wire logic [W-1:0] en_wdata, // new enable value
  output logic [W-1:0] flags, // sticky flags
  output logic [W-1:0] enables, // enable mask
  output logic irq // level interrupt
);

  typedef struct packed {
    logic [W-1:0] flags;
    logic [W-1:0] en;
    logic irq;
  } adcrc_irq_st_t;

  adcrc_irq_st_t st;
  adcrc_irq_st_t next_st;

  // event set beats software clear
  always_comb
  begin
    next_st = st;
    next_st.flags = (st.flags & ~clr) | events;
    if (en_wr)
      next_st.en = en_wdata;
    next_st.irq = |(next_st.flags & next_st.en);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign flags = st.flags;
  assign enables = st.en;
  assign irq = st.irq;

endmodule
`default_nettype wire

// >>> logic/adcrc_regs.sv
// apb register bank for adc results, peek views, trim, bias and interrupts
`timescale 1ns/1ps
`default_nettype none
module adcrc_regs (
  input wire logic pclk, // bus clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [adcrc_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire adcrc_pkg::adcrc_result_t single_res, // single result from core
  input wire adcrc_pkg::adcrc_result_t scan_res, // scan result from core
  input wire logic [31:0] prod_cal, // production trim word
  output adcrc_pkg::adcrc_cal_t cal, // trim to core
  output adcrc_pkg::adcrc_bias_t bias, // bias to core
  output logic single_result_valid, // single data valid
  output logic scan_result_valid, // scan data valid
  output logic single_dma_req, // single dma request
  output logic scan_dma_req, // scan dma request
  output logic irq // interrupt, active high
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    adcrc_pkg::adcrc_cal_t cal;
    adcrc_pkg::adcrc_bias_t bias;
    logic cal_loaded;
  } adcrc_regs_st_t;

  adcrc_regs_st_t st;
  adcrc_regs_st_t next_st;

  logic setup;
  logic wr;
  logic single_consume;
  logic scan_consume;
  logic [31:0] single_data;
  logic [31:0] scan_data;
  logic single_ovf;
  logic scan_ovf;
  logic [adcrc_pkg::IRQ_W-1:0] irq_events;
  logic [adcrc_pkg::IRQ_W-1:0] irq_clr;
  logic [adcrc_pkg::IRQ_W-1:0] irq_flags;
  logic [adcrc_pkg::IRQ_W-1:0] irq_en;
  logic ien_wr;
  logic [31:0] rd_word;

  // true when the address selects the given register
  function automatic logic sel(input logic [adcrc_pkg::ADDR_W-1:0] a, input logic [adcrc_pkg::ADDR_W-1:0] off);
    sel = (a == off);
  endfunction

  // true for any mapped register
  function automatic logic mapped(input logic [adcrc_pkg::ADDR_W-1:0] a);
    mapped = sel(a, adcrc_pkg::OFF_STATUS) | sel(a, adcrc_pkg::OFF_IEN) | sel(a, adcrc_pkg::OFF_IF)
           | sel(a, adcrc_pkg::OFF_IFC) | sel(a, adcrc_pkg::OFF_SINGLE) | sel(a, adcrc_pkg::OFF_SCAN)
           | sel(a, adcrc_pkg::OFF_SINGLE_PEEK) | sel(a, adcrc_pkg::OFF_SCAN_PEEK)
           | sel(a, adcrc_pkg::OFF_CAL) | sel(a, adcrc_pkg::OFF_BIAS);
  endfunction

  // bus phases: read data latched in setup, write applied at access
  assign setup = psel & ~penable;
  assign wr = psel & penable & st.pready & pwrite;

  // ordinary reads consume results; peek reads never do
  assign single_consume = setup & ~pwrite & sel(paddr, adcrc_pkg::OFF_SINGLE);
  assign scan_consume = setup & ~pwrite & sel(paddr, adcrc_pkg::OFF_SCAN);

  // single channel
  adcrc_result_slot u_single (
    .pclk(pclk),
    .presetn(presetn),
    .res(single_res),
    .consume(single_consume),
    .data(single_data),
    .valid(single_result_valid),
    .dma_req(single_dma_req),
    .overflow(single_ovf)
  );

  // scan channel
  adcrc_result_slot u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .res(scan_res),
    .consume(scan_consume),
    .data(scan_data),
    .valid(scan_result_valid),
    .dma_req(scan_dma_req),
    .overflow(scan_ovf)
  );

  // interrupt event and clear vectors
  always_comb
  begin
    irq_events = '0;
    irq_events[adcrc_pkg::IRQ_SINGLE] = single_res.strobe;
    irq_events[adcrc_pkg::IRQ_SCAN] = scan_res.strobe;
    irq_events[adcrc_pkg::IRQ_SINGLE_OF] = single_ovf;
    irq_events[adcrc_pkg::IRQ_SCAN_OF] = scan_ovf;
    irq_clr = '0;
    if (wr && sel(paddr, adcrc_pkg::OFF_IFC))
      irq_clr = pwdata[adcrc_pkg::IRQ_W-1:0] & adcrc_pkg::IRQ_IMPL;
  end

  assign ien_wr = wr & sel(paddr, adcrc_pkg::OFF_IEN);

  // interrupt flags and mask
  adcrc_irq #(
    .W(adcrc_pkg::IRQ_W)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(irq_events),
    .clr(irq_clr),
    .en_wr(ien_wr),
    .en_wdata(pwdata[adcrc_pkg::IRQ_W-1:0] & adcrc_pkg::IRQ_IMPL),
    .flags(irq_flags),
    .enables(irq_en),
    .irq(irq)
  );

  // read multiplexer; unmapped and reserved bits read zero
  always_comb
  begin
    rd_word = 32'h00000000;
    case (1'b1)
      sel(paddr, adcrc_pkg::OFF_STATUS):
      begin
        rd_word[adcrc_pkg::STAT_SINGLE_DV] = single_result_valid;
        rd_word[adcrc_pkg::STAT_SCAN_DV] = scan_result_valid;
      end
      sel(paddr, adcrc_pkg::OFF_IEN): rd_word = {22'h000000, irq_en};
      sel(paddr, adcrc_pkg::OFF_IF): rd_word = {22'h000000, irq_flags};
      sel(paddr, adcrc_pkg::OFF_SINGLE): rd_word = single_data;
      sel(paddr, adcrc_pkg::OFF_SCAN): rd_word = scan_data;
      sel(paddr, adcrc_pkg::OFF_SINGLE_PEEK): rd_word = single_data;
      sel(paddr, adcrc_pkg::OFF_SCAN_PEEK): rd_word = scan_data;
      sel(paddr, adcrc_pkg::OFF_CAL): rd_word = st.cal;
      sel(paddr, adcrc_pkg::OFF_BIAS): rd_word = st.bias;
      default: rd_word = 32'h00000000;
    endcase
  end

  // bus answer, trim and bias update
  always_comb
  begin
    next_st = st;
    next_st.pready = setup; // one wait-free access after each setup
    next_st.pslverr = setup & ~mapped(paddr);
    next_st.prdata = (setup & ~pwrite) ? rd_word : 32'h00000000;
    // production trim taken once after reset release
    if (!st.cal_loaded)
    begin
      next_st.cal = prod_cal & adcrc_pkg::CAL_WMASK;
      next_st.cal_loaded = 1'b1;
    end
    // reserved bits forced to zero on write; offsets stay signed for the core
    if (wr && sel(paddr, adcrc_pkg::OFF_CAL))
      next_st.cal = pwdata & adcrc_pkg::CAL_WMASK;
    if (wr && sel(paddr, adcrc_pkg::OFF_BIAS))
      next_st.bias = pwdata & adcrc_pkg::BIAS_WMASK;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.prdata <= 32'h00000000;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.cal <= adcrc_pkg::CAL_RESET;
      st.bias <= adcrc_pkg::BIAS_RESET;
      st.cal_loaded <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign cal = st.cal;
  assign bias = st.bias;

endmodule
`default_nettype wire

// >>> verification/adcrc_regs_props.sv
// assertion checker for the adc result and trim register bank
`timescale 1ns/1ps
`default_nettype none
module adcrc_regs_props (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [adcrc_pkg::ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // apb ready
  input wire adcrc_pkg::adcrc_result_t single_res, // single result
  input wire adcrc_pkg::adcrc_result_t scan_res, // scan result
  input wire adcrc_pkg::adcrc_cal_t cal, // trim
  input wire adcrc_pkg::adcrc_bias_t bias, // bias
  input wire logic single_result_valid, // single valid
  input wire logic scan_result_valid, // scan valid
  input wire logic single_dma_req, // single dma
  input wire logic scan_dma_req // scan dma
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic su;
  logic wa;
  // read setup and write access
  assign su = psel && !penable && !pwrite;
  assign wa = psel && penable && pready && pwrite;
  property p_srd;
    su && paddr == adcrc_pkg::OFF_SINGLE && !single_res.strobe |=> !single_result_valid && !single_dma_req;
  endproperty
  a_srd: assert property (p_srd) else $error("single read left valid or dma");
  property p_crd;
    su && paddr == adcrc_pkg::OFF_SCAN && !scan_res.strobe |=> !scan_result_valid && !scan_dma_req;
  endproperty
  a_crd: assert property (p_crd) else $error("scan read left valid or dma");
  property p_speek;
    su && paddr == adcrc_pkg::OFF_SINGLE_PEEK && single_result_valid |=> single_result_valid && single_dma_req;
  endproperty
  a_speek: assert property (p_speek) else $error("single peek disturbed status");
  property p_cpeek;
    su && paddr == adcrc_pkg::OFF_SCAN_PEEK && scan_result_valid |=> scan_result_valid && scan_dma_req;
  endproperty
  a_cpeek: assert property (p_cpeek) else $error("scan peek disturbed status");
  property p_sset;
    single_res.strobe |=> single_result_valid && single_dma_req;
  endproperty
  a_sset: assert property (p_sset) else $error("single result not flagged");
  property p_cset;
    scan_res.strobe |=> scan_result_valid && scan_dma_req;
  endproperty
  a_cset: assert property (p_cset) else $error("scan result not flagged");
  property p_calw;
    wa && paddr == adcrc_pkg::OFF_CAL |=> cal == ($past(pwdata) & adcrc_pkg::CAL_WMASK);
  endproperty
  a_calw: assert property (p_calw) else $error("trim write wrong");
  property p_biasw;
    wa && paddr == adcrc_pkg::OFF_BIAS |=> bias == ($past(pwdata) & adcrc_pkg::BIAS_WMASK);
  endproperty
  a_biasw: assert property (p_biasw) else $error("bias write wrong");
  property p_rsv;
    ((cal & ~adcrc_pkg::CAL_WMASK) == 32'h0) && ((bias & ~adcrc_pkg::BIAS_WMASK) == 32'h0);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  // main scenarios
  c_peek: cover property (su && paddr == adcrc_pkg::OFF_SINGLE_PEEK && single_result_valid);
  c_win: cover property (su && paddr == adcrc_pkg::OFF_SINGLE && single_res.strobe);
  c_calw: cover property (wa && paddr == adcrc_pkg::OFF_CAL);
endmodule
bind adcrc_regs adcrc_regs_props adcrc_regs_props_inst (.*);
`default_nettype wire

// >>> verification/adcrc_regs_tb.sv
// self-checking bench for the adc result and trim register bank
`timescale 1ns/1ps
`default_nettype none
module adcrc_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic single_result_valid, scan_result_valid, single_dma_req, scan_dma_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prod_cal, rdat;
  adcrc_pkg::adcrc_result_t single_res, scan_res;
  adcrc_pkg::adcrc_cal_t cal;
  adcrc_pkg::adcrc_bias_t bias;
  int errors = 0;
  int cmp_count = 0;
  adcrc_regs adcrc_regs_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .single_res(single_res),
    .scan_res(scan_res),
    .prod_cal(prod_cal),
    .cal(cal),
    .bias(bias),
    .single_result_valid(single_result_valid),
    .scan_result_valid(scan_result_valid),
    .single_dma_req(single_dma_req),
    .scan_dma_req(scan_dma_req),
    .irq(irq)
  );
  // 50 ns clock
  always #25 pclk = ~pclk;
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, optional single strobe in setup; waits for pready, then one idle edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic st);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    single_res <= {st, 32'h00005A01};
    @(posedge pclk);
    penable <= 1;
    single_res <= '0;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk); // idle edge; the next call can re-drive psel in this same time step, after the DUT has sampled it low
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(0, a, 32'h0, 0);
    chk(nm, e, rdat);
  endtask
  task automatic pulse(input int s, input logic [31:0] d);
    if (s == 1)
      scan_res <= {1'b1, d};
    else
      single_res <= {1'b1, d};
    @(posedge pclk);
    scan_res <= '0;
    single_res <= '0;
    @(posedge pclk);
  endtask
  task automatic irqc(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge pclk);
  endtask
  // watchdog
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    single_res = '0;
    scan_res = '0;
    prod_cal = 32'hC1A2B3C4;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
      rd(12'(36 + 4 * i), 32'h0, "result reset");
    rd(adcrc_pkg::OFF_CAL, 32'h41223344, "trim reset");
    chk("slverr mapped", 32'h0, {31'h0, rerr});
    rd(adcrc_pkg::OFF_BIAS, 32'h00000747, "bias reset");
    xfer(1, adcrc_pkg::OFF_CAL, 32'h7F7F7F7F, 0);
    rd(adcrc_pkg::OFF_CAL, 32'h7F7F7F7F, "trim");
    xfer(1, adcrc_pkg::OFF_CAL, 32'h00400040, 0);
    chk("offset sign", 32'h1, {31'h0, $signed(cal.single_offset_trim) < 0});
    xfer(1, adcrc_pkg::OFF_BIAS, 32'h00000F4F, 0);
    rd(adcrc_pkg::OFF_BIAS, 32'h00000F4F, "bias");
    chk("bias port", 32'h00000F4F, bias);
    for (int s = 0; s < 2; s++)
    begin
      pulse(s, 32'hA5C30000 + s);
      rd(12'(44 + 4 * s), 32'hA5C30000 + s, "peek");
      rd(adcrc_pkg::OFF_STATUS, 32'h1 << s, "status kept");
      chk("dma kept", 32'h1, {31'h0, s == 1 ? scan_dma_req : single_dma_req});
      rd(12'(36 + 4 * s), 32'hA5C30000 + s, "result");
      rd(adcrc_pkg::OFF_STATUS, 32'h0, "status cleared");
      chk("dma gone", 32'h0, {31'h0, s == 1 ? scan_dma_req : single_dma_req});
    end
    xfer(1, adcrc_pkg::OFF_SCAN_PEEK, 32'hFFFFFFFF, 0);
    rd(adcrc_pkg::OFF_SCAN_PEEK, 32'hA5C30001, "read only");
    irqc(0);
    xfer(1, adcrc_pkg::OFF_IEN, 32'h1, 0);
    irqc(1);
    xfer(1, adcrc_pkg::OFF_IFC, 32'h0, 0);
    irqc(1);
    xfer(1, adcrc_pkg::OFF_IFC, 32'h1, 0);
    irqc(0);
    rd(adcrc_pkg::OFF_IF, 32'h2, "flags");
    pulse(0, 32'h11110000);
    xfer(0, adcrc_pkg::OFF_SINGLE, 32'h0, 1);
    chk("set wins data", 32'h11110000, rdat);
    rd(adcrc_pkg::OFF_STATUS, 32'h1, "set wins");
    chk("dma set wins", 32'h1, {31'h0, single_dma_req});
    rd(adcrc_pkg::OFF_SINGLE_PEEK, 32'h00005A01, "new data");
    // two scan results with no read between: overflow flag and newest data
    pulse(1, 32'h00001234);
    pulse(1, 32'h00005678);
    rd(adcrc_pkg::OFF_IF, 32'h00000203, "overflow flag");
    rd(adcrc_pkg::OFF_SCAN, 32'h00005678, "overwritten");
    xfer(0, 12'h100, 32'h0, 0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    print_verdict();
  end
endmodule
`default_nettype wire
